/* logic/paper_tape_ctrl.sv */
// paper tape reader and punch controller core with its register slave
//
// Contract
// - continuous mode keeps reader tape moving, capturing characters until stopped; punch ignores it.
// - write command routes transfers to punch; read command routes them to reader.
// - interrupts enabled in read mode: interrupt while a character waits in buffer.
// - interrupts enabled in write mode: interrupt while another character can be accepted.
// - clear disables interrupts and sets busy, tape stopped and attention flags.
// - clear selects interrupts disabled, stopped, single step and read mode.
// - clear turns punch motor off unless power button is held down.
// - remote button released means punch local; depressed means punch remote.
// - remote with power button released: run command turns punch power on.
// - remote with power button released: stop command turns punch power off.
// - power button down forces power on; otherwise remote follows program, local off.
// - read command strobes the character under the sense lights into the buffer.
// - write command stops the reader, leaving the next character unread.
// - device number is 03 hex for reader only, 13 hex with a punch.
// - busy: read mode while buffer empty, write mode while buffer full.
// - single step: advance one character, then wait until a data read.
// - continuous mode reload before take sets overrun; attention is overrun or stopped.
// - reader stop halts after next character; punch stop after next punch, power off.
`timescale 1ns/100ps
`include "ptrp_defines.svh"
module paper_tape_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic system_clear_switch,
	input wire logic punch_fitted,
	input wire logic [7:0] reader_char,
	input wire logic reader_char_strobe,
	input wire logic reader_unavail,
	output logic reader_advance,
	input wire logic punch_remote_button,
	input wire logic punch_power_button,
	input wire logic punch_low_tape,
	input wire logic punch_done,
	output logic [7:0] punch_char,
	output logic punch_strobe,
	output logic punch_power,
	output logic ext_irq
);
	regbus_if rb();

	axil_regs_slave u_slave (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rb(rb.bus_side)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic int_en_reg, int_en_next, mode_write_reg, mode_write_next;
	logic run_reg, run_next, single_reg, single_next, cont_reg, cont_next;
	logic rstop_reg, rstop_next, pstop_reg, pstop_next, prog_reg, prog_next;
	logic full_reg, full_next, overrun_reg, overrun_next, stopped_reg, stopped_next;
	ptrp_pkg::byte_t buf_reg, buf_next, pchar_next, devnum_reg, devnum_next;
	ptrp_pkg::byte_t select_reg, select_next, cmd_view, status_view;
	ptrp_pkg::reader_state_e rstate_reg, rstate_next;
	ptrp_pkg::punch_state_e pstate_reg, pstate_next;
	logic strap_done_reg, strap_done_next, pstrobe_next, power_next, irq_next;
	logic clear, selected, remote, prog_ok, cmd_wr, data_wr, data_rd;
	ptrp_pkg::byte_t cmd;

	// the clear switch resets the controller but not the host-side select register
	assign clear = ~aresetn | system_clear_switch;
	assign selected = (select_reg == devnum_reg);
	assign remote = punch_remote_button;
	assign prog_ok = remote & ~punch_power_button;
	assign cmd = rb.wr_data;
	assign cmd_wr = rb.wr_en & rb.wr_lane0 & selected & hit(rb.wr_addr, `OFS_COMMAND);
	assign data_wr = rb.wr_en & rb.wr_lane0 & selected & hit(rb.wr_addr, `OFS_DATA);
	assign data_rd = rb.rd_en & selected & hit(rb.rd_addr, `OFS_DATA);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		int_en_next = int_en_reg;
		mode_write_next = mode_write_reg;
		run_next = run_reg;
		single_next = single_reg;
		cont_next = cont_reg;
		rstop_next = rstop_reg;
		pstop_next = pstop_reg;
		prog_next = prog_reg;
		full_next = full_reg;
		overrun_next = overrun_reg;
		stopped_next = stopped_reg;
		buf_next = buf_reg;
		rstate_next = rstate_reg;
		pstate_next = pstate_reg;
		pchar_next = punch_char;
		pstrobe_next = 1'b0;
		// reader motion, only while the reader owns the buffer
		if (!mode_write_reg) begin
			if (data_rd) begin
				full_next = 1'b0;
			end
			case (rstate_reg)
				ptrp_pkg::READER_STOPPED: begin
					if (run_reg && (cont_reg || !full_reg)) begin
						rstate_next = ptrp_pkg::READER_MOVING;
					end
				end
				ptrp_pkg::READER_MOVING: begin
					if (reader_char_strobe) begin
						if (cont_reg && full_reg && !data_rd) begin
							overrun_next = 1'b1;
						end
						buf_next = reader_char;
						full_next = 1'b1;
						if (rstop_reg) begin
							rstate_next = ptrp_pkg::READER_STOPPED;
							stopped_next = 1'b1;
							rstop_next = 1'b0;
						end else if (single_reg) begin
							rstate_next = ptrp_pkg::READER_STOPPED;
						end
					end
				end
				default: rstate_next = ptrp_pkg::READER_STOPPED;
			endcase
		end
		// punch side; a started punch cycle always completes
		if (mode_write_reg && data_wr && !full_reg) begin
			buf_next = rb.wr_data;
			full_next = 1'b1;
		end
		case (pstate_reg)
			ptrp_pkg::PUNCH_IDLE: begin
				if (mode_write_reg && full_reg && remote && punch_power) begin
					pstrobe_next = 1'b1;
					pchar_next = buf_reg;
					pstate_next = ptrp_pkg::PUNCH_BUSY;
				end
			end
			ptrp_pkg::PUNCH_BUSY: begin
				if (punch_done) begin
					pstate_next = ptrp_pkg::PUNCH_IDLE;
					if (mode_write_reg) begin
						full_next = 1'b0;
					end
					if (pstop_reg) begin
						prog_next = 1'b0;
						pstop_next = 1'b0;
					end
				end
			end
			default: pstate_next = ptrp_pkg::PUNCH_IDLE;
		endcase
		// commands are applied last so they win over motion in the same cycle
		if (cmd_wr) begin
			if (cmd[`CMD_ENABLE]) begin
				int_en_next = 1'b1;
			end else if (cmd[`CMD_DISABLE]) begin
				int_en_next = 1'b0;
			end
			if (cmd[`CMD_SINGLE_STEP_MODE]) begin
				single_next = 1'b1;
				cont_next = 1'b0;
			end else if (cmd[`CMD_CONTINUOUS_READ_MODE]) begin
				cont_next = 1'b1;
				single_next = 1'b0;
			end
			if (cmd[`CMD_RUN]) begin
				run_next = 1'b1;
				// a fresh run cancels a pending punch stop so power is not dropped later
				pstop_next = 1'b0;
				rstop_next = 1'b0;
				stopped_next = 1'b0;
				if (prog_ok) begin
					prog_next = 1'b1;
				end
			end
			// stop wins over run given in the same byte
			if (cmd[`CMD_STOP]) begin
				run_next = 1'b0;
				if (rstate_reg == ptrp_pkg::READER_MOVING) begin
					rstop_next = 1'b1;
				end else begin
					stopped_next = 1'b1;
				end
				if (prog_ok) begin
					if (mode_write_reg && full_reg) begin
						pstop_next = 1'b1;
					end else begin
						prog_next = 1'b0;
					end
				end
			end
			if (cmd[`CMD_WRITE]) begin
				mode_write_next = 1'b1;
				full_next = 1'b0;
				overrun_next = 1'b0;
				rstate_next = ptrp_pkg::READER_STOPPED;
				run_next = 1'b0;
				rstop_next = 1'b0;
				stopped_next = 1'b1;
			end else if (cmd[`CMD_READ]) begin
				mode_write_next = 1'b0;
				buf_next = reader_char;
				full_next = 1'b1;
				overrun_next = 1'b0;
			end
		end
		power_next = punch_power_button | (remote & prog_next & ~clear);
		irq_next = int_en_reg & (mode_write_reg ? ~full_reg : full_reg);
		strap_done_next = 1'b1;
		devnum_next = strap_done_reg ? devnum_reg : (punch_fitted ? `DEVNUM_WITH_PUNCH : `DEVNUM_READER_ONLY);
		select_next = select_reg;
		if (rb.wr_en && rb.wr_lane0 && hit(rb.wr_addr, `OFS_SELECT)) begin
			select_next = rb.wr_data;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (clear) begin
			int_en_reg <= 1'b0;
			mode_write_reg <= 1'b0;
			run_reg <= 1'b0;
			single_reg <= 1'b1;
			cont_reg <= 1'b0;
			rstop_reg <= 1'b0;
			pstop_reg <= 1'b0;
			prog_reg <= 1'b0;
			full_reg <= 1'b0;
			overrun_reg <= 1'b0;
			stopped_reg <= 1'b1;
			buf_reg <= 8'h00;
			rstate_reg <= ptrp_pkg::READER_STOPPED;
			reader_advance <= 1'b0;
			pstate_reg <= ptrp_pkg::PUNCH_IDLE;
			punch_char <= 8'h00;
			punch_strobe <= 1'b0;
			ext_irq <= 1'b0;
			strap_done_reg <= 1'b0;
			devnum_reg <= `DEVNUM_READER_ONLY;
		end else begin
			int_en_reg <= int_en_next;
			mode_write_reg <= mode_write_next;
			run_reg <= run_next;
			single_reg <= single_next;
			cont_reg <= cont_next;
			rstop_reg <= rstop_next;
			pstop_reg <= pstop_next;
			prog_reg <= prog_next;
			full_reg <= full_next;
			overrun_reg <= overrun_next;
			stopped_reg <= stopped_next;
			buf_reg <= buf_next;
			rstate_reg <= rstate_next;
			reader_advance <= (rstate_next == ptrp_pkg::READER_MOVING);
			pstate_reg <= pstate_next;
			punch_char <= pchar_next;
			punch_strobe <= pstrobe_next;
			ext_irq <= irq_next;
			strap_done_reg <= strap_done_next;
			devnum_reg <= devnum_next;
		end
	end

	// power follows the buttons even during clear, so it has no reset branch
	always_ff @(posedge aclk) begin
		punch_power <= power_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			select_reg <= `SELECT_RESET;
		end else begin
			select_reg <= select_next;
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_comb begin
		cmd_view = {~int_en_reg, int_en_reg, ~run_reg, run_reg, single_reg, cont_reg, mode_write_reg, ~mode_write_reg};
		status_view = 8'h00;
		if (mode_write_reg) begin
			status_view[`ST_BUSY] = full_reg;
			status_view[`ST_UNAVAIL] = ~punch_power | ~remote | punch_low_tape;
		end else begin
			status_view[`ST_OVERRUN] = overrun_reg;
			status_view[`ST_STOPPED] = stopped_reg;
			status_view[`ST_BUSY] = ~full_reg;
			status_view[`ST_ATTN] = overrun_reg | stopped_reg;
			status_view[`ST_UNAVAIL] = reader_unavail;
		end
		rb.rd_data = 8'h00;
		rb.rd_err = 1'b0;
		if (hit(rb.rd_addr, `OFS_COMMAND)) begin
			rb.rd_data = selected ? cmd_view : 8'h00;
		end else if (hit(rb.rd_addr, `OFS_STATUS)) begin
			rb.rd_data = selected ? status_view : 8'h00;
		end else if (hit(rb.rd_addr, `OFS_DATA)) begin
			rb.rd_data = selected ? buf_reg : 8'h00;
		end else if (hit(rb.rd_addr, `OFS_DEVNUM)) begin
			rb.rd_data = devnum_reg;
		end else if (hit(rb.rd_addr, `OFS_SELECT)) begin
			rb.rd_data = select_reg;
		end else begin
			rb.rd_err = 1'b1;
		end
		rb.wr_err = ~(hit(rb.wr_addr, `OFS_COMMAND) | hit(rb.wr_addr, `OFS_STATUS) | hit(rb.wr_addr, `OFS_DATA)
			| hit(rb.wr_addr, `OFS_DEVNUM) | hit(rb.wr_addr, `OFS_SELECT));
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (clear);

	sequence s_run_remote;
		cmd_wr && cmd[`CMD_RUN] && !cmd[`CMD_STOP] && prog_ok ##1 prog_ok;
	endsequence
	sequence s_stop_idle;
		cmd_wr && cmd[`CMD_STOP] && !(mode_write_reg && full_reg) && prog_ok ##1 prog_ok;
	endsequence

	AST_CLEAR_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
		system_clear_switch |=> !int_en_reg && stopped_reg && !full_reg && !ext_irq)
		else $error("clear did not set flags");
	AST_CLEAR_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
		system_clear_switch |=> single_reg && !cont_reg && !run_reg && !mode_write_reg)
		else $error("clear did not set command state");
	AST_READ_STROBE: assert property (cmd_wr && cmd[`CMD_READ] && !cmd[`CMD_WRITE]
		|=> full_reg && buf_reg == $past(reader_char) && !mode_write_reg)
		else $error("read command did not strobe character");
	AST_WRITE_STOPS: assert property (cmd_wr && cmd[`CMD_WRITE]
		|=> !reader_advance && !full_reg && mode_write_reg)
		else $error("write command did not stop reader");
	AST_IRQ_READ: assert property (int_en_reg && !mode_write_reg && full_reg ##1 !mode_write_reg
		|-> ext_irq)
		else $error("read interrupt missing");
	AST_IRQ_WRITE: assert property (int_en_reg && mode_write_reg && !full_reg |=> ext_irq)
		else $error("write interrupt missing");
	AST_RUN_POWER: assert property (s_run_remote |=> punch_power)
		else $error("run did not power punch");
	AST_STOP_POWER: assert property (s_stop_idle |=> !punch_power)
		else $error("stop did not remove punch power");
	AST_BUTTON_POWER: assert property (punch_power_button |=> punch_power)
		else $error("power button ignored");
	AST_LOCAL_OFF: assert property (!remote && !punch_power_button |=> !punch_power)
		else $error("local punch powered");
	AST_SINGLE_STEP: assert property (reader_advance && single_reg && !rstop_reg && reader_char_strobe
		&& !mode_write_reg && !cmd_wr |=> (!reader_advance && full_reg) ##1 !reader_advance)
		else $error("single step did not stop after one character");
	AST_OVERRUN: assert property (reader_advance && cont_reg && full_reg && reader_char_strobe
		&& !data_rd && !cmd_wr && !mode_write_reg |=> overrun_reg)
		else $error("overrun not flagged");
	AST_DEVNUM: assert property (strap_done_reg |-> devnum_reg ==
		(punch_fitted ? `DEVNUM_WITH_PUNCH : `DEVNUM_READER_ONLY))
		else $error("wrong device number");
	AST_READ_BUSY: assert property (data_rd && !mode_write_reg && !reader_char_strobe && !cmd_wr
		|=> !full_reg)
		else $error("data read did not set busy");
endmodule : paper_tape_ctrl

/* logic/ptrp_defines.svh */
// register map, bit positions, reset values and bus answers for the tape controller
`ifndef PTRP_DEFINES_SVH
`define PTRP_DEFINES_SVH
`define OFS_COMMAND 8'h00
`define OFS_STATUS 8'h04
`define OFS_DATA 8'h08
`define OFS_DEVNUM 8'h0c
`define OFS_SELECT 8'h10
`define CMD_DISABLE 7
`define CMD_ENABLE 6
`define CMD_STOP 5
`define CMD_RUN 4
`define CMD_SINGLE_STEP_MODE 3
`define CMD_CONTINUOUS_READ_MODE 2
`define CMD_WRITE 1
`define CMD_READ 0
`define ST_OVERRUN 7
`define ST_STOPPED 4
`define ST_BUSY 3
`define ST_ATTN 2
`define ST_UNAVAIL 0
`define DEVNUM_READER_ONLY 8'h03
`define DEVNUM_WITH_PUNCH 8'h13
`define SELECT_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* logic/ptrp_pkg.sv */
// types shared by the tape controller modules
package ptrp_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic {READER_STOPPED, READER_MOVING} reader_state_e;
	typedef enum logic {PUNCH_IDLE, PUNCH_BUSY} punch_state_e;
endpackage : ptrp_pkg

/* logic/regbus_if.sv */
// register access strobes between the bus slave and the controller core
`timescale 1ns/100ps
interface regbus_if;
	logic wr_en;
	logic wr_lane0;
	logic [7:0] wr_addr;
	ptrp_pkg::byte_t wr_data;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	ptrp_pkg::byte_t rd_data;
	logic rd_err;
	modport bus_side (output wr_en, wr_lane0, wr_addr, wr_data, rd_en, rd_addr, input wr_err, rd_data, rd_err);
	modport core_side (input wr_en, wr_lane0, wr_addr, wr_data, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface : regbus_if

/* logic/axil_regs_slave.sv */
// AXI4-Lite slave that turns bus transfers into one-cycle register strobes
`timescale 1ns/100ps
`include "ptrp_defines.svh"
module axil_regs_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	regbus_if.bus_side rb
);
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next, ar_held_reg, ar_held_next;
	logic [7:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic lane0_reg, lane0_next;
	logic awready_next, wready_next, arready_next, bvalid_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	logic fire_w, fire_r;

	// strobes come from held flops, so the core sees one clean pulse per transfer
	assign fire_w = aw_held_reg & w_held_reg & ~bvalid;
	assign fire_r = ar_held_reg & ~rvalid;
	assign rb.wr_en = fire_w;
	assign rb.wr_addr = waddr_reg;
	assign rb.wr_data = wbyte_reg;
	assign rb.wr_lane0 = lane0_reg;
	assign rb.rd_en = fire_r;
	assign rb.rd_addr = raddr_reg;

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		ar_held_next = ar_held_reg;
		waddr_next = waddr_reg;
		raddr_next = raddr_reg;
		wbyte_next = wbyte_reg;
		lane0_next = lane0_reg;
		bvalid_next = bvalid;
		bresp_next = bresp;
		rvalid_next = rvalid;
		rresp_next = rresp;
		rdata_next = rdata;
		if (awvalid && awready) begin
			aw_held_next = 1'b1;
			waddr_next = awaddr;
		end
		if (wvalid && wready) begin
			w_held_next = 1'b1;
			wbyte_next = wdata[7:0];
			lane0_next = wstrb[0];
		end
		if (bvalid && bready) begin
			bvalid_next = 1'b0;
		end
		if (fire_w) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = rb.wr_err ? `RESP_SLVERR : `RESP_OKAY;
		end
		if (arvalid && arready) begin
			ar_held_next = 1'b1;
			raddr_next = araddr;
		end
		if (rvalid && rready) begin
			rvalid_next = 1'b0;
		end
		if (fire_r) begin
			ar_held_next = 1'b0;
			rvalid_next = 1'b1;
			rdata_next = {24'h000000, rb.rd_data};
			rresp_next = rb.rd_err ? `RESP_SLVERR : `RESP_OKAY;
		end
		awready_next = ~aw_held_next & ~bvalid_next;
		wready_next = ~w_held_next & ~bvalid_next;
		arready_next = ~ar_held_next & ~rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			ar_held_reg <= 1'b0;
			waddr_reg <= 8'h00;
			raddr_reg <= 8'h00;
			wbyte_reg <= 8'h00;
			lane0_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `RESP_OKAY;
			rdata <= 32'h00000000;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			ar_held_reg <= ar_held_next;
			waddr_reg <= waddr_next;
			raddr_reg <= raddr_next;
			wbyte_reg <= wbyte_next;
			lane0_reg <= lane0_next;
			awready <= awready_next;
			wready <= wready_next;
			arready <= arready_next;
			bvalid <= bvalid_next;
			bresp <= bresp_next;
			rvalid <= rvalid_next;
			rresp <= rresp_next;
			rdata <= rdata_next;
		end
	end
endmodule : axil_regs_slave

/* sim/tape_model.sv */
// behavioural reader transport and punch mechanism facing the controller
`timescale 1ns/100ps
module tape_model (
	input wire logic aclk,
	input wire logic reader_advance,
	input wire logic punch_strobe,
	output logic [7:0] reader_char,
	output logic reader_char_strobe,
	output logic punch_done
);
	logic [2:0] step_reg;
	logic [3:0] punch_cnt_reg;
	initial begin
		reader_char = 8'h40;
		reader_char_strobe = 1'h0;
		punch_done = 1'h0;
		step_reg = 3'h0;
		punch_cnt_reg = 4'h0;
	end
	// tape only moves while the drive is on, so a stopped reader keeps its character under the lights
	always @(posedge aclk) begin
		step_reg <= reader_advance ? step_reg + 3'h1 : 3'h0;
		reader_char_strobe <= reader_advance && step_reg == 3'h5;
		if (reader_advance && step_reg == 3'h5)
			reader_char <= reader_char + 8'h01;
		punch_done <= punch_cnt_reg == 4'h1;
		punch_cnt_reg <= punch_strobe ? 4'h9 : (punch_cnt_reg != 4'h0 ? punch_cnt_reg - 4'h1 : 4'h0);
	end
endmodule : tape_model

/* sim/paper_tape_reader_punch_ctrl_test.sv */
// self-checking bench for the paper tape controller over its register bus
`timescale 1ns/100ps
`include "ptrp_defines.svh"
module paper_tape_reader_punch_ctrl_test;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic clr = 1'h0, remote = 1'h0, pwr_btn = 1'h0, fitted = 1'h1;
	logic awready, wready, bvalid, arready, rvalid, rstrobe, radv, pstrobe, pdone, ppower, irq;
	logic [1:0] bresp, rresp, rs, ws;
	logic [31:0] rdata;
	logic [7:0] rchar, pchar, rv;
	logic [7:0] punched = 8'h00;
	int error_cnt = 0;
	int check_count = 0;
	always #25 aclk = ~aclk;
	paper_tape_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .system_clear_switch(clr),
		.punch_fitted(fitted), .reader_char(rchar), .reader_char_strobe(rstrobe), .reader_unavail(1'h0),
		.reader_advance(radv), .punch_remote_button(remote), .punch_power_button(pwr_btn),
		.punch_low_tape(1'h0), .punch_done(pdone), .punch_char(pchar), .punch_strobe(pstrobe),
		.punch_power(ppower), .ext_irq(irq));
	tape_model mech (.aclk(aclk), .reader_advance(radv), .punch_strobe(pstrobe), .reader_char(rchar),
		.reader_char_strobe(rstrobe), .punch_done(pdone));
	always @(posedge aclk) if (pstrobe === 1'h1) punched <= pchar;
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'h1) awvalid <= 1'h0;
			if (wvalid && wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		ws = bresp;
		bready <= 1'h0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rv = rdata[7:0];
		rs = rresp;
		rready <= 1'h0;
	endtask : axr
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		axr(a);
		chk(what, exp, rv);
	endtask : rdc
	// polls status, giving up after a bounded number of reads
	task automatic wait_status(input int bitpos, input logic val);
		int n;
		n = 0;
		do begin
			axr(`OFS_STATUS);
			n++;
		end while (rv[bitpos] !== val && n < 60);
		chk("status bit wait", val, rv[bitpos]);
	endtask : wait_status
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rdc("devnum", `OFS_DEVNUM, `DEVNUM_WITH_PUNCH);
		axw(`OFS_SELECT, `DEVNUM_WITH_PUNCH);
		rdc("status after reset", `OFS_STATUS, 8'h1c);
		rdc("command after reset", `OFS_COMMAND, 8'ha9);
		axr(8'h20);
		chk("unmapped resp", `RESP_SLVERR, rs);
		axw(8'h20, 8'h00);
		chk("unmapped write resp", `RESP_SLVERR, ws);
		chk("irq after reset", 1'h0, irq);
		axw(`OFS_COMMAND, 8'h59);
		repeat (2) @(posedge aclk);
		chk("irq char waiting", 1'h1, irq);
		rdc("strobed char", `OFS_DATA, 8'h40);
		wait_status(`ST_BUSY, 1'h0);
		chk("single step stopped", 1'h0, radv);
		rdc("next char", `OFS_DATA, 8'h41);
		axw(`OFS_COMMAND, 8'h55);
		wait_status(`ST_OVERRUN, 1'h1);
		chk("overrun and attention", 8'h84, rv & 8'h84);
		axw(`OFS_COMMAND, 8'h20);
		wait_status(`ST_STOPPED, 1'h1);
		chk("reader halted", 1'h0, radv);
		rdc("command held", `OFS_COMMAND, 8'h65);
		remote <= 1'h1;
		axw(`OFS_COMMAND, 8'h52);
		repeat (2) @(posedge aclk);
		chk("reader stopped by write", 1'h0, radv);
		chk("program power on", 1'h1, ppower);
		chk("irq ready for char", 1'h1, irq);
		axw(`OFS_DATA, 8'ha5);
		rdc("busy while full", `OFS_STATUS, 8'h08);
		wait_status(`ST_BUSY, 1'h0);
		chk("punched char", 8'ha5, punched);
		axw(`OFS_COMMAND, 8'h20);
		repeat (2) @(posedge aclk);
		chk("program power off", 1'h0, ppower);
		axw(`OFS_COMMAND, 8'h52);
		remote <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("local power off", 1'h0, ppower);
		pwr_btn <= 1'h1;
		clr <= 1'h1;
		repeat (2) @(posedge aclk);
		clr <= 1'h0;
		chk("button keeps power", 1'h1, ppower);
		rdc("status after clear", `OFS_STATUS, 8'h1c);
		rdc("command after clear", `OFS_COMMAND, 8'ha9);
		pwr_btn <= 1'h0;
		remote <= 1'h1;
		axw(`OFS_COMMAND, 8'h10);
		repeat (2) @(posedge aclk);
		chk("power before clear", 1'h1, ppower);
		fitted <= 1'h0;
		clr <= 1'h1;
		repeat (2) @(posedge aclk);
		clr <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("clear removes power", 1'h0, ppower);
		rdc("devnum reader only", `OFS_DEVNUM, `DEVNUM_READER_ONLY);
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		wrap_up();
	end
endmodule : paper_tape_reader_punch_ctrl_test
